// ==== logic/crc_divider.sv ====
// Tick divider: one output pulse for every DIV input ticks
`timescale 1ns/1ns
module crc_divider #(
  parameter int DIV = 12
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic clear,
  input  wire logic tick_in,
  output wire logic tick_out
);

  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } crc_div_s;

  crc_div_s st;
  crc_div_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Count input ticks, pulse on the last one of each group
  always_comb begin
    next_st     = st;
    next_st.out = 1'b0;
    if (clear) begin
      next_st.cnt = '0;
    end else if (tick_in) begin
      if (st.cnt == CW'(DIV - 1)) begin
        next_st.cnt = '0;
        next_st.out = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CW'(1);
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign tick_out = st.out;

endmodule // crc_divider

// ==== logic/crc_top.sv ====
// Clock source selection, safeguard filter, dividers and reset sequencing
//
// Overview of operation
// RQ1 - Internal clock divided by 12 for peripherals and by 13 for core.
// RQ2 - Instructions last two, four or five machine cycles.
// RQ3 - Factory option picks crystal/resonator/external clock or RC network source.
// RQ4 - With safeguard, setting oscillator-off bit stops main, starts auxiliary oscillator.
// RQ5 - Main oscillator restarts on bit clear or on any reset.
// RQ6 - Auxiliary exists only with safeguard; takes over one period after missing edge.
// RQ7 - On auxiliary clock everything runs normally, only slower.
// RQ8 - At power-on auxiliary clock feeds the delay counter until main runs.
// RQ9 - Auxiliary oscillator switches off once main oscillator runs.
// RQ10 - Safeguard drops excess edges keeping internal clock below its maximum.
// RQ11 - Safeguard holds internal frequency at maximum when oscillator runs faster.
// RQ12 - Four reset sources: pin, power-on, watchdog, low voltage.
// RQ13 - Active-low reset pin, extended by a delay, so short pulses work.
// RQ14 - Held in reset while pin low; accepted in run, wait, stop.
// RQ15 - Reset halts execution, pulls up inputs, restarts main oscillator.
// RQ16 - After release, initialisation starts only when internal delay expires.
// RQ17 - Reset in stop starts oscillator, pulls up inputs, then delays.
// RQ18 - Delay is 2048 cycles when option low, 32768 when high.
// RQ19 - Safeguard active only when its option bit is high.
// RQ20 - Watchdog reset behaves exactly like pin reset, delay included.
// RQ21 - Internal reset sources drive the reset pin low.
// RQ22 - Clock switching between oscillators is glitch-free.
// RQ23 - Reset pin synchronised before the delay counter starts.
`timescale 1ns/1ns
module crc_top #(
  parameter int DELAY_SHORT_CYC = crc_pkg::DELAY_SHORT,
  parameter int DELAY_LONG_CYC  = crc_pkg::DELAY_LONG
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  // Factory options
  input  wire logic       safeguard_option_bit,
  input  wire logic       delay_option_bit,
  input  wire logic       osc_rc_option,
  // Oscillators
  input  wire logic       osc_input_pin,
  input  wire logic       aux_low_freq_osc,
  output wire logic       main_osc_enable,
  output wire logic       osc_rc_mode,
  output wire logic       aux_osc_enable,
  // Internal clock and its divided ticks
  output wire logic       internal_clock_tick,
  output wire logic       periph_tick,
  output wire logic       core_tick,
  output wire logic       on_aux_clock,
  // Instruction timing
  input  wire logic       instr_start,
  input  wire logic [1:0] instr_len_sel,
  output wire logic       instr_done,
  // Reset sources and pin
  input  wire logic       reset_pin_in,
  input  wire logic       power_on_detect,
  input  wire logic       watchdog_timeout,
  input  wire logic       low_voltage_detect,
  input  wire logic       stop_mode,
  output wire logic       reset_pin_out,
  output wire logic       reset_pin_oe_n,
  output wire logic       internal_reset,
  output wire logic       io_pullup_inputs,
  output wire logic       cpu_run,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output wire logic [7:0] reg_rdata
);

  localparam int GW = $clog2(crc_pkg::SG_GAP_CYC + 1);
  localparam int MW = $clog2(crc_pkg::MISS_CYC + 1);
  localparam int EW = $clog2(crc_pkg::GOOD_EDGES + 1);
  localparam int DW = $clog2(DELAY_LONG_CYC + 1);

  typedef struct packed {
    logic              osc_q;
    logic              pin_s1;
    logic              pin_s2;
    logic [7:0]        ctrl;
    crc_pkg::crc_src_e src;
    logic              aux_arm;
    logic [GW-1:0]     gap_cnt;
    logic [MW-1:0]     miss_cnt;
    logic [EW-1:0]     good_cnt;
    logic              int_tick;
    crc_pkg::crc_rst_e rst_state;
    logic [DW-1:0]     dly_cnt;
    logic              drive_pin;
    logic              instr_busy;
    logic [2:0]        instr_left;
    logic              instr_fin;
    logic [7:0]        rdata;
  } crc_state_s;

  crc_state_s st;
  crc_state_s next_st;

  logic          sg_on;
  logic          main_on;
  logic          main_edge;
  logic          edge_ok;
  logic          missing;
  logic          aux_tick;
  logic          any_source;
  logic          internal_source;
  logic          in_reset;
  logic [DW-1:0] dly_last;
  logic [2:0]    instr_cyc;
  logic          core_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode of the current state
  always_comb begin
    sg_on           = safeguard_option_bit;                               // [RQ19]
    // Oscillator-off bit only bites with the safeguard, else there is no backup clock;
    // any reset restarts main at once, before the register reload lands
    main_on         = !(sg_on && st.ctrl[crc_pkg::CTRL_OSC_OFF_BIT]
                        && st.rst_state == crc_pkg::RS_RUN);              // [RQ4] [RQ5]
    main_edge       = main_on && osc_input_pin && !st.osc_q;
    // Edges arriving inside the minimum period are spikes and are dropped
    edge_ok         = main_edge && (!sg_on || st.gap_cnt == '0);          // [RQ10] [RQ11]
    missing         = !main_on || st.miss_cnt == MW'(crc_pkg::MISS_CYC);
    aux_tick        = aux_low_freq_osc && sg_on && (st.aux_arm || st.src == crc_pkg::SRC_AUX);
    internal_source = power_on_detect || watchdog_timeout || low_voltage_detect;
    any_source      = !st.pin_s2 || internal_source;                      // [RQ12] [RQ20]
    in_reset        = st.rst_state != crc_pkg::RS_RUN;
    dly_last        = delay_option_bit ? DW'(DELAY_LONG_CYC - 1)
                                       : DW'(DELAY_SHORT_CYC - 1);        // [RQ18]
    case (instr_len_sel)
      2'h0:    instr_cyc = crc_pkg::INSTR_CYC_2;
      2'h1:    instr_cyc = crc_pkg::INSTR_CYC_4;
      default: instr_cyc = crc_pkg::INSTR_CYC_5;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st          = st;
    next_st.osc_q    = osc_input_pin;
    next_st.int_tick = 1'b0;
    next_st.instr_fin = 1'b0;
    next_st.rdata    = '0;

    // Two flops on the reset pin before anything looks at it
    next_st.pin_s1 = reset_pin_in;                                        // [RQ23]
    next_st.pin_s2 = st.pin_s1;                                           // [RQ23]

    // Safeguard gap counter restarts on every accepted main edge
    if (edge_ok || (st.src == crc_pkg::SRC_AUX && aux_tick)) begin
      next_st.gap_cnt = GW'(crc_pkg::SG_GAP_CYC - 1);                     // [RQ10]
    end else if (st.gap_cnt != '0) begin
      next_st.gap_cnt = st.gap_cnt - GW'(1);
    end

    // Silence watchdog on the main oscillator
    if (main_edge) begin
      next_st.miss_cnt = '0;
    end else if (!missing) begin
      next_st.miss_cnt = st.miss_cnt + MW'(1);
    end

    // Clock source selection; switches happen only on a tick of the source
    // being entered, so the internal clock never sees a short pulse
    if (!sg_on) begin
      next_st.src      = crc_pkg::SRC_MAIN;                               // [RQ6]
      next_st.aux_arm  = 1'b0;
      next_st.good_cnt = '0;
      next_st.int_tick = main_edge;                                       // [RQ3]
    end else if (st.src == crc_pkg::SRC_MAIN) begin
      next_st.int_tick = edge_ok;
      if (missing) begin
        next_st.aux_arm = 1'b1;                                           // [RQ4] [RQ6]
      end else if (main_edge) begin
        // Main is back before the aux tick: cancel, else two ticks could crowd
        next_st.aux_arm = 1'b0;                                           // [RQ9] [RQ22]
      end
      if (st.aux_arm && aux_tick) begin
        // First aux tick comes one aux period after the miss was seen
        next_st.src      = crc_pkg::SRC_AUX;                              // [RQ6] [RQ22]
        next_st.aux_arm  = 1'b0;
        next_st.good_cnt = '0;
        next_st.int_tick = 1'b1;
      end
    end else begin
      next_st.int_tick = aux_tick;                                        // [RQ7] [RQ8]
      if (missing) begin
        next_st.good_cnt = '0;
      end else if (edge_ok && !aux_tick) begin
        if (st.good_cnt == EW'(crc_pkg::GOOD_EDGES - 1)) begin
          // Main is running again: hand back and stop the aux oscillator
          next_st.src      = crc_pkg::SRC_MAIN;                           // [RQ9] [RQ22]
          next_st.good_cnt = '0;
          next_st.int_tick = 1'b1;
        end else begin
          next_st.good_cnt = st.good_cnt + EW'(1);
        end
      end
    end

    // Reset sequencer; the delay counts internal clock ticks, which are aux
    // ticks while the main oscillator is still starting
    case (st.rst_state)
      crc_pkg::RS_HOLD: begin
        next_st.dly_cnt = '0;
        if (!any_source) begin
          next_st.rst_state = crc_pkg::RS_DELAY;                          // [RQ14]
        end
      end
      crc_pkg::RS_DELAY: begin
        if (any_source) begin
          next_st.rst_state = crc_pkg::RS_HOLD;
        end else if (st.int_tick) begin
          if (st.dly_cnt == dly_last) begin
            next_st.rst_state = crc_pkg::RS_RUN;                          // [RQ16] [RQ13]
          end else begin
            next_st.dly_cnt = st.dly_cnt + DW'(1);                        // [RQ8] [RQ18]
          end
        end
      end
      crc_pkg::RS_RUN: begin
        if (any_source) begin
          next_st.rst_state = crc_pkg::RS_HOLD;                           // [RQ12] [RQ14]
        end
      end
      default: begin
        next_st.rst_state = crc_pkg::RS_HOLD;
      end
    endcase

    // Only internal sources pull the pin; the pin itself must not latch us
    next_st.drive_pin = internal_source;                                  // [RQ21]

    // Control register: reloaded by any reset so the main oscillator restarts
    if (in_reset) begin
      next_st.ctrl = crc_pkg::CTRL_RESET;                                 // [RQ5] [RQ15]
    end else if (reg_wr && reg_addr == crc_pkg::ADDR_CONV_CTRL) begin
      next_st.ctrl = reg_wdata;                                           // [RQ4]
    end
    if (reg_rd && reg_addr == crc_pkg::ADDR_CONV_CTRL) begin
      next_st.rdata = st.ctrl;
    end

    // Instruction length counter in machine cycles
    if (in_reset) begin
      next_st.instr_busy = 1'b0;
      next_st.instr_left = '0;
    end else if (!st.instr_busy) begin
      if (instr_start) begin
        next_st.instr_busy = 1'b1;                                        // [RQ2]
        next_st.instr_left = instr_cyc;
      end
    end else if (core_pulse) begin
      if (st.instr_left == 3'h1) begin
        next_st.instr_busy = 1'b0;
        next_st.instr_fin  = 1'b1;                                        // [RQ2]
      end else begin
        next_st.instr_left = st.instr_left - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st           <= '0;
      st.osc_q     <= osc_input_pin;  // A high pin at release is not a fresh edge
      st.ctrl      <= crc_pkg::CTRL_RESET;
      st.src       <= crc_pkg::SRC_MAIN;
      st.rst_state <= crc_pkg::RS_HOLD;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers of the internal clock; cleared in reset so phases start aligned
  crc_divider #(
    .DIV (crc_pkg::DIV_PERIPH)
  ) u_div_periph (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .clear    (in_reset),
    .tick_in  (st.int_tick),
    .tick_out (periph_tick)
  );                                                                      // [RQ1]

  crc_divider #(
    .DIV (crc_pkg::DIV_CORE)
  ) u_div_core (
    .clock    (clock),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .clear    (in_reset),
    .tick_in  (st.int_tick),
    .tick_out (core_pulse)
  );                                                                      // [RQ1]

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // In stop the oscillator sleeps, but a reset wakes it for the delay
  assign main_osc_enable     = main_on && (!stop_mode || in_reset);       // [RQ17] [RQ15]
  assign osc_rc_mode         = osc_rc_option;                             // [RQ3]
  assign aux_osc_enable      = sg_on && (st.aux_arm || st.src == crc_pkg::SRC_AUX); // [RQ9]
  assign internal_clock_tick = st.int_tick;
  assign core_tick           = core_pulse;
  assign on_aux_clock        = st.src == crc_pkg::SRC_AUX;
  assign instr_done          = st.instr_fin;
  assign reset_pin_out       = 1'b0;
  assign reset_pin_oe_n      = !st.drive_pin;                             // [RQ21]
  assign internal_reset      = in_reset;                                  // [RQ13]
  assign io_pullup_inputs    = in_reset;                                  // [RQ15] [RQ17]
  assign cpu_run             = !in_reset;                                 // [RQ15]
  assign reg_rdata           = st.rdata;

endmodule // crc_top

// ==== shared/crc_pkg.sv ====
// Constants, enumerations and timing for the clock and reset control block
package crc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_CONV_CTRL   = 8'hD1;  // Converter control register
  localparam int         CTRL_OSC_OFF_BIT = 2;      // Main oscillator off bit
  localparam logic [7:0] CTRL_RESET       = 8'h40;  // Reset value of the register

  ////////////////////////////////////////////////////////////////////////////
  // Divider ratios of the internal clock
  localparam int DIV_PERIPH = 12;  // Timer, converter and watchdog
  localparam int DIV_CORE   = 13;  // Processor core machine cycle

  ////////////////////////////////////////////////////////////////////////////
  // Stabilisation delay in oscillator cycles
  localparam int DELAY_SHORT = 2048;
  localparam int DELAY_LONG  = 32768;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, derived from the system clock period
  localparam int CLK_PERIOD_NS    = 8;
  localparam int SG_MIN_PERIOD_NS = 125;   // Shortest internal clock period allowed
  localparam int SG_GAP_CYC       = (SG_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MISS_TIME_NS     = 1000;  // Silence that counts as a missing edge
  localparam int MISS_CYC         = MISS_TIME_NS / CLK_PERIOD_NS;
  localparam int GOOD_EDGES       = 8;     // Main edges needed before handing back

  ////////////////////////////////////////////////////////////////////////////
  // Instruction lengths in machine cycles
  localparam logic [2:0] INSTR_CYC_2 = 3'h2;
  localparam logic [2:0] INSTR_CYC_4 = 3'h4;
  localparam logic [2:0] INSTR_CYC_5 = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic {SRC_MAIN, SRC_AUX} crc_src_e;
  typedef enum logic [1:0] {RS_HOLD, RS_DELAY, RS_RUN} crc_rst_e;

endpackage

// ==== sim/crc_osc_model.sv ====
// Crystal and auxiliary oscillator model facing the clock block
`timescale 1ns/1ns
module crc_osc_model (
  input  wire logic       clock,
  input  wire logic       enable,
  input  wire logic [7:0] half_cyc,
  output logic            osc_input_pin,
  output logic            aux_low_freq_osc
);
  logic [7:0] hcnt = 8'h00;
  logic [5:0] acnt = 6'h00;

  // Crystal toggles every half_cyc cycles; a stopped crystal rests low, not at its last level
  always @(posedge clock) begin
    if (!enable) begin
      osc_input_pin <= 1'b0;
      hcnt <= 8'h00;
    end else if (hcnt >= half_cyc - 8'h01) begin
      osc_input_pin <= ~osc_input_pin;
      hcnt <= 8'h00;
    end else begin
      hcnt <= hcnt + 8'h01;
    end
  end

  // Slow auxiliary pulse every 50 cycles; the block ignores it unless armed or already running on it
  always @(posedge clock) begin
    acnt <= (acnt == 6'd49) ? 6'h00 : acnt + 6'h01;
    aux_low_freq_osc <= (acnt == 6'h00);
  end
  initial osc_input_pin = 1'b0;
  initial aux_low_freq_osc = 1'b0;
endmodule // crc_osc_model

// ==== sim/crc_top_chk.sv ====
// Port-level assertions for the clock and reset control block
`timescale 1ns/1ns
module crc_top_chk (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       safeguard_option_bit,
  input wire logic       osc_rc_option,
  input wire logic       osc_rc_mode,
  input wire logic       main_osc_enable,
  input wire logic       internal_clock_tick,
  input wire logic       periph_tick,
  input wire logic       core_tick,
  input wire logic       on_aux_clock,
  input wire logic       reset_pin_in,
  input wire logic       power_on_detect,
  input wire logic       watchdog_timeout,
  input wire logic       low_voltage_detect,
  input wire logic       reset_pin_oe_n,
  input wire logic       internal_reset,
  input wire logic       io_pullup_inputs,
  input wire logic       cpu_run,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  ////////////////////////////////////////
  logic [7:0] gap;
  logic [4:0] pcnt;
  logic [4:0] ccnt;
  logic       pval;
  logic       cval;
  wire        src = power_on_detect | watchdog_timeout | low_voltage_detect;

  // Cycles since the last internal tick, saturating so idle spans never wrap
  always_ff @(posedge clock) begin
    if (!nrst) begin
      gap <= 8'hFF;
    end else if (internal_clock_tick) begin
      gap <= 8'h01;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end

  // Ticks per divided pulse; dividers restart in reset, so the first period is not judged
  always_ff @(posedge clock) begin
    if (!nrst || internal_reset) begin
      pcnt <= 5'h00;
      ccnt <= 5'h00;
      pval <= 1'b0;
      cval <= 1'b0;
    end else begin
      pcnt <= periph_tick ? 5'h00 : pcnt + 5'(internal_clock_tick);
      ccnt <= core_tick ? 5'h00 : ccnt + 5'(internal_clock_tick);
      pval <= pval | periph_tick;
      cval <= cval | core_tick;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_pin_low;
    !reset_pin_in [*3];
  endsequence
  sequence s_osc_off_wr;
    reg_wr && reg_addr == crc_pkg::ADDR_CONV_CTRL && reg_wdata[2] && !internal_reset;
  endsequence

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  chk_src_drive: assert property (src |=> internal_reset && !reset_pin_oe_n)
    else $error("internal source did not reset and pull the pin");
  chk_pin_free: assert property (!src |=> reset_pin_oe_n)
    else $error("pin pulled with no internal source");
  chk_pin_reset: assert property (s_pin_low |=> internal_reset)
    else $error("low reset pin did not reset");
  chk_run_state: assert property (cpu_run == !internal_reset
    && io_pullup_inputs == internal_reset)
    else $error("run or pull-up state disagrees with reset");
  chk_rc_mode: assert property (osc_rc_mode == osc_rc_option)
    else $error("source option not passed on");
  chk_sg_gap: assert property (internal_clock_tick && safeguard_option_bit && !on_aux_clock
    && !$past(on_aux_clock) |-> gap >= 8'h10)
    else $error("internal ticks closer than the safeguard limit");
  chk_osc_off: assert property (s_osc_off_wr ##0 safeguard_option_bit
    |=> !main_osc_enable)
    else $error("oscillator-off bit did not stop main oscillator");
  chk_periph_div: assert property (periph_tick && pval |-> pcnt == 5'h0C)
    else $error("peripheral pulse not every 12 ticks");
  chk_core_div: assert property (core_tick && cval |-> ccnt == 5'h0D)
    else $error("core pulse not every 13 ticks");
  chk_aux_gate: assert property (!safeguard_option_bit |-> !on_aux_clock)
    else $error("auxiliary clock used without safeguard");
  chk_reset_osc: assert property (internal_reset |-> main_osc_enable)
    else $error("main oscillator not running in reset");
endmodule // crc_top_chk

// ==== sim/tb_clock_and_reset_control.sv ====
// Self-checking testbench for the clock and reset control block
`timescale 1ns/1ns
module tb_clock_and_reset_control;
  localparam int DS = 8;
  localparam int DL = 16;
  localparam logic [7:0] AD = crc_pkg::ADDR_CONV_CTRL;
  logic       clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, board_n = 1'b1;
  logic       safeguard_option_bit = 1'b0, delay_option_bit = 1'b0, osc_rc_option = 1'b0;
  logic       instr_start = 1'b0, stop_mode = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       power_on_detect = 1'b0, watchdog_timeout = 1'b0, low_voltage_detect = 1'b0;
  logic [1:0] instr_len_sel = 2'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, osc_half = 8'h14;
  logic       osc_input_pin, aux_low_freq_osc, main_osc_enable, osc_rc_mode, aux_osc_enable;
  logic       internal_clock_tick, periph_tick, core_tick, on_aux_clock, instr_done;
  logic       reset_pin_out, reset_pin_oe_n, internal_reset, io_pullup_inputs, cpu_run;
  logic [7:0] reg_rdata;
  wire        reset_pin_in = board_n & (reset_pin_oe_n | reset_pin_out);
  int         n_mismatch = 0, n_tests = 0;

  crc_top #(.DELAY_SHORT_CYC(DS), .DELAY_LONG_CYC(DL)) crc_top_inst (.*);
  crc_osc_model crc_osc_model_inst (.clock, .enable(main_osc_enable), .half_cyc(osc_half),
    .osc_input_pin, .aux_low_freq_osc);

  // Free-running 125 MHz clock
  always #4 clock = ~clock;

  ////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Values read at an edge are those of the cycle before it, so no race with the block
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  task automatic count_ticks(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge clock);
      n += internal_clock_tick;
    end
  endtask
  // Reset with options, then count internal ticks until the core is let go
  task automatic t_delay(input logic sg, input logic dly);
    int n, k, e;
    e = dly ? DL : DS;
    n = 0;
    nrst <= 1'b0;
    safeguard_option_bit <= sg;
    delay_option_bit <= dly;
    osc_rc_option <= dly;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    for (k = 0; k < 4000 && internal_reset !== 1'b0; k++) begin
      @(posedge clock);
      n += internal_clock_tick;
    end
    check(n == e || n == e + 1, "stabilisation delay length");
  endtask
  task automatic t_reg();
    logic [7:0] d;
    rd(AD, d);
    check(d === crc_pkg::CTRL_RESET, "control reset value");
    wr(8'hD0, 8'hFF);
    rd(8'hD0, d);
    check(d === 8'h00, "unmapped read not zero");
    wr(AD, 8'hA3);
    rd(AD, d);
    check(d === 8'hA3, "control read back");
  endtask
  task automatic t_osc_off();
    int k, n;
    wr(AD, 8'h44);
    @(posedge clock);
    check(main_osc_enable === 1'b0, "main oscillator still on");
    for (k = 0; k < 1000 && on_aux_clock !== 1'b1; k++) @(posedge clock);
    check(aux_osc_enable === 1'b1 && on_aux_clock === 1'b1, "no auxiliary takeover");
    count_ticks(500, n);
    check(n >= 9 && n <= 11, "auxiliary tick rate");
    wr(AD, 8'h40);
    for (k = 0; k < 1000 && on_aux_clock !== 1'b0; k++) @(posedge clock);
    check(main_osc_enable === 1'b1 && aux_osc_enable === 1'b0, "aux kept on");
  endtask
  // One-cycle pulse from each internal reset source, four cycles low on the pin, while the main oscillator is switched off
  task automatic t_resets();
    int i, k, n;
    for (i = 0; i < 4; i++) begin
      wr(AD, 8'h04);
      stop_mode <= i[0];
      board_n <= (i != 0);
      power_on_detect <= (i == 1);
      watchdog_timeout <= (i == 2);
      low_voltage_detect <= (i == 3);
      // Pin held low four cycles so a held level is exercised, not only a blip
      repeat (i == 0 ? 4 : 1) @(posedge clock);
      {board_n, power_on_detect, watchdog_timeout, low_voltage_detect} <= 4'h8;
      repeat (5) @(posedge clock);
      check(internal_reset === 1'b1 && io_pullup_inputs === 1'b1, "no reset");
      check(main_osc_enable === 1'b1, "oscillator not restarted");
      n = 0;
      for (k = 0; k < 4000 && internal_reset !== 1'b0; k++) begin
        @(posedge clock);
        n += internal_clock_tick;
      end
      check(n >= DS - 1 && n <= DS + 1, "post-reset delay");
    end
    stop_mode <= 1'b0;
  endtask
  task automatic t_spike();
    int n;
    osc_half <= 8'h02;
    t_delay(1'b1, 1'b0);
    count_ticks(480, n);
    check(n >= 28 && n <= 31, "safeguard cap");
    t_delay(1'b0, 1'b0);
    count_ticks(480, n);
    check(n >= 119 && n <= 121, "unfiltered tick rate");
  endtask
  task automatic t_instr();
    int s, k, n;
    int lens[4] = '{2, 4, 5, 5};
    for (s = 0; s < 4; s++) begin
      for (k = 0; k < 200 && core_tick !== 1'b1; k++) @(posedge clock);
      instr_start <= 1'b1;
      instr_len_sel <= s[1:0];
      @(posedge clock);
      instr_start <= 1'b0;
      n = 0;
      for (k = 0; k < 800 && instr_done !== 1'b1; k++) begin
        @(posedge clock);
        n += core_tick;
      end
      check(n == lens[s] && k < 800, "machine cycles per instruction");
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    @(posedge clock);
    t_delay(1'b0, 1'b1);
    t_delay(1'b1, 1'b0);
    t_reg();
    t_osc_off();
    t_resets();
    t_spike();
    t_instr();
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule // tb_clock_and_reset_control

bind crc_top crc_top_chk crc_top_chk_inst (.*);
